/* wdt_defines.vh */
// Purpose: constants for the slow clock watchdog timer
// Assumes: register indices are printed offsets; byte address is index times four
// Notes: included by both design files
//
// Contract
// [RQ1] run-enable set starts counting up from zero
// [RQ2] terminal count gives four slow-cycle reset pulse
// [RQ3] after watchdog reset execution restarts at zero
// [RQ4] refresh one reloads and restarts; zero ignored
// [RQ5] reload register supplies counter high byte
// [RQ6] standby or sleep freezes and keeps count
// [RQ7] watchdog disabled under emulation or debug
// [RQ8] watchdog reset sets its reset-cause flag
// [RQ9] software refreshes before terminal count
// [RQ10] reload writable before and after enabling
// [RQ11] counter advances on slow clock only
// [RQ12] enable and reload reset to zero
// [RQ13] sixteen-bit counter; refresh loads reload, zero
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// register indices, byte address is index times four
`define IDX_CLOCK_CONFIG_ONE    16'h401E
`define IDX_WATCHDOG_CONTROL    16'h4026
`define IDX_WATCHDOG_RELOAD     16'h4027
`define IDX_RESET_CAUSE         16'h4030
`define IDX_WATCHDOG_COUNT      16'h4031

// field positions
`define BIT_FAST_CLOCK_MODE     0
`define BIT_LOW_VOLT_IRQ_EN     6
`define BIT_WATCHDOG_RUN_ENABLE 5
`define BIT_WATCHDOG_REFRESH    0
`define BIT_RESET_CAUSE_WDT     0

// reset values
`define RST_CLOCK_CONFIG_ONE    8'h00
`define RST_WATCHDOG_RELOAD     8'h00
`define RST_WATCHDOG_COUNT      16'h0000

// timing and counting
`define WDT_TERMINAL_COUNT      16'hFFFF
`define WDT_PULSE_SLOW_CYCLES   3'h4
`define WDT_RESTART_ADDRESS     16'h0000

`endif

/* slow_tick_detect.v */
// Purpose: turn the asynchronous slow clock into one-cycle ticks on clk
// Assumes: slow clock is much slower than clk (under a quarter of its rate)
// Notes: two flops of synchronisation before the edge detector
`timescale 1ns/100ps
`include "wdt_defines.vh"

module slow_tick_detect
(
  // system
  input  wire clk,
  input  wire rst_n,
  // slow clock pin
  input  wire slow_clk,
  // rising edge of the slow clock, one clk wide
  output reg  slow_tick
);

  reg  [2:0] stage;
  wire [3:0] chain;

  assign chain[0] = slow_clk;

  // stage 0 and 1 synchronise, stage 2 only feeds the edge detector
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_stage
      always @(posedge clk)
      begin
        if (!rst_n)
          stage[i] <= 1'b0;
        else
          stage[i] <= chain[i];
      end
      assign chain[i+1] = stage[i];
    end
  endgenerate

  always @(posedge clk)
  begin
    if (!rst_n)
      slow_tick <= 1'b0;
    else
      slow_tick <= stage[1] & ~stage[2]; // [RQ11]
  end

endmodule

/* slow_clock_watchdog_timer.v */
// Purpose: watchdog counter on the internal slow clock with an APB register port
// Assumes: standby, sleep and debug inputs come from logic on clk
// Notes: one wait state on every APB access; unmapped addresses answer pslverr
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`include "wdt_defines.vh"

module slow_clock_watchdog_timer
(
  // system
  input  wire        clk,
  input  wire        rst_n,
  // internal slow clock, asynchronous to clk
  input  wire        slow_clk,
  // power and debug state
  input  wire        standby_mode,
  input  wire        sleep_mode,
  input  wire        debug_mode,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [17:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // system reset request and restart vector
  output reg         wdt_reset_pulse,
  output reg  [15:0] restart_address,
  // visible state
  output reg         watchdog_active,
  output reg  [15:0] watchdog_count
);

  // pulse state, one-hot
  localparam [1:0] ST_RUN   = 2'b01;
  localparam [1:0] ST_PULSE = 2'b10;

  reg  [1:0]  state;
  reg         watchdog_run_enable;
  reg         fast_clock_mode;
  reg         low_volt_irq_en;
  reg  [7:0]  watchdog_reload_value;
  reg         watchdog_reset_cause_flag;
  reg         run_enable_seen;
  reg  [2:0]  pulse_ticks;

  wire        slow_tick;
  wire        access;
  wire        wr_go;
  wire        rd_go;
  wire        lane0;
  wire        mapped;
  wire        refresh_req;
  wire        count_allowed;
  wire        at_terminal;

  wire        hit_config;
  wire        hit_control;
  wire        hit_reload;
  wire        hit_cause;
  wire        hit_count;
  wire        wr_config;
  wire        wr_reload;
  wire        clear_cause;
  wire        overflow;
  wire        pulse_done;

  reg  [31:0] next_prdata;
  reg         next_run_enable;
  reg         next_fast_clock;
  reg         next_low_volt;
  reg  [7:0]  next_reload;
  reg  [1:0]  next_state;
  reg  [15:0] next_count;
  reg         next_seen;
  reg  [2:0]  next_ticks;
  reg         next_pulse;

  slow_tick_detect slow_tick_detect_inst
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .slow_clk  (slow_clk),
    .slow_tick (slow_tick)
  );

  // index decode; addresses are word aligned, low two bits must be zero
  function reg_hit;
    input [17:0] addr;
    input [15:0] index;
    begin
      reg_hit = (addr[1:0] == 2'b00) && (addr[17:2] == index);
    end
  endfunction

  // second cycle of the access phase carries the answer
  assign access  = psel & penable & ~pready;
  assign wr_go   = access & pwrite & mapped;
  assign rd_go   = access & ~pwrite;
  assign lane0   = pstrb[0];
  assign mapped  = hit_config | hit_control | hit_reload | hit_cause | hit_count;

  // each register decoded here for the map check, the writes and the flag; the refresh and the read mux decode again
  assign hit_config  = reg_hit(paddr, `IDX_CLOCK_CONFIG_ONE);
  assign hit_control = reg_hit(paddr, `IDX_WATCHDOG_CONTROL);
  assign hit_reload  = reg_hit(paddr, `IDX_WATCHDOG_RELOAD);
  assign hit_cause   = reg_hit(paddr, `IDX_RESET_CAUSE);
  assign hit_count   = reg_hit(paddr, `IDX_WATCHDOG_COUNT);
  assign wr_config   = wr_go & lane0 & hit_config;
  assign wr_reload   = wr_go & lane0 & hit_reload;
  assign clear_cause = wr_go & lane0 & hit_cause & pwdata[`BIT_RESET_CAUSE_WDT];

  // a zero written to the refresh bit does nothing
  assign refresh_req = wr_go & lane0 & reg_hit(paddr, `IDX_WATCHDOG_CONTROL) &
                       pwdata[`BIT_WATCHDOG_REFRESH]; // [RQ4]

  // frozen in low power, off under debug
  assign count_allowed = watchdog_run_enable & ~standby_mode & ~sleep_mode &
                         ~debug_mode; // [RQ6] [RQ7]

  assign at_terminal = (watchdog_count == `WDT_TERMINAL_COUNT);

  // one condition starts the pulse and sets the flag, so they never disagree
  assign overflow   = (state == ST_RUN) & run_enable_seen & ~refresh_req &
                      count_allowed & slow_tick & at_terminal;
  assign pulse_done = (state == ST_PULSE) & slow_tick &
                      (pulse_ticks == `WDT_PULSE_SLOW_CYCLES - 3'h1);

  // bus answer
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access;
      pslverr <= access & ~mapped;
      if (rd_go)
        prdata <= next_prdata;
    end
  end

  always @*
  begin
    next_prdata = 32'h0000_0000;
    if (reg_hit(paddr, `IDX_CLOCK_CONFIG_ONE))
    begin
      next_prdata[`BIT_FAST_CLOCK_MODE]     = fast_clock_mode;
      next_prdata[`BIT_LOW_VOLT_IRQ_EN]     = low_volt_irq_en;
      next_prdata[`BIT_WATCHDOG_RUN_ENABLE] = watchdog_run_enable;
    end
    else if (reg_hit(paddr, `IDX_WATCHDOG_RELOAD))
      next_prdata[7:0] = watchdog_reload_value;
    else if (reg_hit(paddr, `IDX_RESET_CAUSE))
      next_prdata[`BIT_RESET_CAUSE_WDT] = watchdog_reset_cause_flag;
    else if (reg_hit(paddr, `IDX_WATCHDOG_COUNT))
      next_prdata[15:0] = watchdog_count;
  end

  // software registers; a watchdog reset clears the settings like a chip reset
  always @*
  begin
    next_run_enable = watchdog_run_enable;
    next_fast_clock = fast_clock_mode;
    next_low_volt   = low_volt_irq_en;
    next_reload     = watchdog_reload_value;
    if (state == ST_PULSE)
    begin
      next_run_enable = 1'b0;
      next_fast_clock = 1'b0;
      next_low_volt   = 1'b0;
      next_reload     = `RST_WATCHDOG_RELOAD;
    end
    else
    begin
      if (wr_config)
      begin
        next_run_enable = pwdata[`BIT_WATCHDOG_RUN_ENABLE];
        next_fast_clock = pwdata[`BIT_FAST_CLOCK_MODE];
        next_low_volt   = pwdata[`BIT_LOW_VOLT_IRQ_EN];
      end
      // accepted whether or not the watchdog runs
      if (wr_reload)
        next_reload = pwdata[7:0]; // [RQ10]
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      watchdog_run_enable   <= 1'b0; // [RQ12]
      watchdog_reload_value <= `RST_WATCHDOG_RELOAD; // [RQ12]
      fast_clock_mode       <= 1'b0;
      low_volt_irq_en       <= 1'b0;
    end
    else
    begin
      watchdog_run_enable   <= next_run_enable;
      watchdog_reload_value <= next_reload;
      fast_clock_mode       <= next_fast_clock;
      low_volt_irq_en       <= next_low_volt;
    end
  end

  // reset-cause flag survives the watchdog reset; set wins over clear
  always @(posedge clk)
  begin
    if (!rst_n)
      watchdog_reset_cause_flag <= 1'b0;
    else if (overflow)
      watchdog_reset_cause_flag <= 1'b1; // [RQ8]
    else if (clear_cause)
      watchdog_reset_cause_flag <= 1'b0;
  end

  // next values of the counter and the pulse
  always @*
  begin
    next_state = state;
    next_count = watchdog_count;
    next_seen  = run_enable_seen;
    next_ticks = pulse_ticks;
    next_pulse = wdt_reset_pulse;

    case (state)
      ST_RUN:
      begin
        // enable edge restarts from zero; a refresh beats a same-cycle tick
        next_seen = watchdog_run_enable;
        if (!watchdog_run_enable)
          next_count = `RST_WATCHDOG_COUNT;
        else if (!run_enable_seen)
          next_count = `RST_WATCHDOG_COUNT; // [RQ1]
        else if (refresh_req)
          next_count = {watchdog_reload_value, 8'h00}; // [RQ5] [RQ13]
        else if (overflow)
        begin
          next_state = ST_PULSE;
          next_pulse = 1'b1; // [RQ2]
          next_ticks = 3'h0;
        end
        else if (count_allowed && slow_tick)
          next_count = watchdog_count + 16'h0001; // [RQ11]
      end
      ST_PULSE:
      begin
        // the pulse counts raw slow edges, low power does not stretch it
        if (pulse_done)
        begin
          next_state = ST_RUN;
          next_pulse = 1'b0; // [RQ2]
          next_count = `RST_WATCHDOG_COUNT;
          next_seen  = 1'b0;
        end
        else if (slow_tick)
          next_ticks = pulse_ticks + 3'h1;
      end
      default:
      begin
        next_state = ST_RUN;
        next_pulse = 1'b0;
      end
    endcase
  end

  // counter and reset pulse
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state           <= ST_RUN;
      watchdog_count  <= `RST_WATCHDOG_COUNT;
      run_enable_seen <= 1'b0;
      pulse_ticks     <= 3'h0;
      wdt_reset_pulse <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      watchdog_count  <= next_count;
      run_enable_seen <= next_seen;
      pulse_ticks     <= next_ticks;
      wdt_reset_pulse <= next_pulse;
    end
  end

  // status outputs, one clk behind the state they report
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      restart_address <= `WDT_RESTART_ADDRESS;
      watchdog_active <= 1'b0;
    end
    else
    begin
      restart_address <= `WDT_RESTART_ADDRESS; // [RQ3]
      watchdog_active <= count_allowed & (state == ST_RUN);
    end
  end

endmodule

/* slow_clock_watchdog_timer_assertions.sv */
// Purpose: port checker for the slow clock watchdog
// Assumes: slow clock period of ten clk cycles
// Notes: bound from the testbench top
`timescale 1ns/100ps
module slow_clock_watchdog_timer_assertions
(
  // system and mode
  input wire        clk,
  input wire        rst_n,
  input wire        standby_mode,
  input wire        sleep_mode,
  input wire        debug_mode,
  // apb and watchdog outputs
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire        wdt_reset_pulse,
  input wire [15:0] restart_address,
  input wire        watchdog_active,
  input wire [15:0] watchdog_count
);
  wire      frz = standby_mode | sleep_mode | debug_mode;
  reg [7:0] plen;
  always @(posedge clk)
    if (!rst_n || !wdt_reset_pulse)
      plen <= 8'h00;
    else
      plen <= plen + 8'h01;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ready_next;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready held");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
  property p_restart;
    restart_address == 16'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not zero");
  // one extra cycle of freeze covers a registered mode flag
  property p_freeze;
    frz && $past(frz) && $past(frz, 2) && !$past(psel) && !$past(wdt_reset_pulse)
      |-> $stable(watchdog_count);
  endproperty
  a_freeze: assert property (p_freeze) else $error("count moved");
  property p_debug;
    debug_mode && $past(debug_mode) |-> !watchdog_active;
  endproperty
  a_debug: assert property (p_debug) else $error("active in debug");
  property p_pulse_top;
    $rose(wdt_reset_pulse) |-> watchdog_count == 16'hffff;
  endproperty
  a_pulse_top: assert property (p_pulse_top) else $error("early pulse");
  property p_pulse_len;
    $fell(wdt_reset_pulse) |-> plen >= 8'h26 && plen <= 8'h2a;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse width");
  c_pulse: cover property ($rose(wdt_reset_pulse));
  c_err: cover property (pslverr);
  c_frz: cover property (frz && watchdog_count != 16'h0000);
endmodule

/* slow_clock_watchdog_timer_test.sv */
// Purpose: self-checking bench for the slow clock watchdog
// Assumes: slow clock runs free at ten clk periods
// Notes: byte address is register index times four
`timescale 1ns/100ps
`include "wdt_defines.vh"
module slow_clock_watchdog_timer_test;
  reg         clk;
  reg         rst_n;
  reg         slow_clk;
  reg         standby_mode;
  reg         sleep_mode;
  reg         debug_mode;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [17:0] paddr;
  reg  [31:0] pwdata;
  reg  [3:0]  pstrb;
  wire        pready;
  wire [31:0] prdata;
  wire        pslverr;
  wire        wdt_reset_pulse;
  wire [15:0] restart_address;
  wire        watchdog_active;
  wire [15:0] watchdog_count;
  integer     err_count;
  integer     total_checks;
  integer     n;
  reg  [31:0] rd;
  reg         err;
  reg  [15:0] c;
  slow_clock_watchdog_timer slow_clock_watchdog_timer_inst
  (
    .clk, .rst_n, .slow_clk, .standby_mode, .sleep_mode, .debug_mode,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .wdt_reset_pulse, .restart_address, .watchdog_active, .watchdog_count
  );
  task apb(input w, input [15:0] idx, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task check(input [63:0] nm, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("mismatch %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task t_start;
    begin
      apb(1'b0, `IDX_WATCHDOG_RELOAD, 32'h0000_0000);
      check("reload", 0, rd);
      apb(1'b1, `IDX_WATCHDOG_RELOAD, 32'h0000_0003);
      apb(1'b1, `IDX_CLOCK_CONFIG_ONE, 32'h0000_0020);
      repeat (2) @(posedge clk);
      check("start", 1, watchdog_count < 16'h0002);
      repeat (50) @(posedge clk);
      check("slow", 1, watchdog_count > 16'h0003 && watchdog_count < 16'h0007);
      apb(1'b1, `IDX_WATCHDOG_CONTROL, 32'h0000_0000);
      check("norefr", 0, watchdog_count[15:8]);
      apb(1'b1, `IDX_WATCHDOG_CONTROL, 32'h0000_0001);
      check("refresh", 3, watchdog_count[15:8]);
      check("active", 1, watchdog_active);
      check("low", 1, watchdog_count[7:0] < 8'h02);
      $display("test start done");
    end
  endtask
  task t_freeze;
    integer m;
    begin
      for (m = 0; m < 3; m = m + 1)
      begin
        @(posedge clk);
        {standby_mode, sleep_mode, debug_mode} <= 3'h4 >> m;
        repeat (5) @(posedge clk);
        c = watchdog_count;
        repeat (40) @(posedge clk);
        check("frozen", c, watchdog_count);
        check("active", 0, watchdog_active);
        {standby_mode, sleep_mode, debug_mode} <= 3'h0;
        repeat (30) @(posedge clk);
        check("resume", 1, watchdog_count != c);
      end
      $display("test freeze done");
    end
  endtask
  task t_overflow;
    begin
      apb(1'b1, `IDX_WATCHDOG_RELOAD, 32'h0000_00ff);
      apb(1'b1, `IDX_WATCHDOG_CONTROL, 32'h0000_0001);
      n = 0;
      while (wdt_reset_pulse !== 1'b1 && n < 4000)
      begin
        @(posedge clk);
        n = n + 1;
      end
      check("pulse", 1, wdt_reset_pulse);
      check("restart", 0, restart_address);
      n = 0;
      while (wdt_reset_pulse === 1'b1 && n < 100)
      begin
        @(posedge clk);
        n = n + 1;
      end
      check("width", 1, n > 36 && n < 44);
      apb(1'b0, `IDX_RESET_CAUSE, 32'h0000_0000);
      check("cause", 1, rd[0]);
      check("cnt0", 0, watchdog_count);
      apb(1'b1, `IDX_RESET_CAUSE, 32'h0000_0001);
      apb(1'b0, `IDX_RESET_CAUSE, 32'h0000_0000);
      check("cleared", 0, rd[0]);
      apb(1'b0, `IDX_CLOCK_CONFIG_ONE, 32'h0000_0000);
      check("cfg0", 0, rd);
      apb(1'b0, 16'h4020, 32'h0000_0000);
      check("slverr", 1, err);
      check("rdata", 0, rd);
      $display("test overflow done");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    slow_clk = 1'b0;
    forever #200 slow_clk = ~slow_clk;
  end
  initial
  begin
    #800000;
    err_count = err_count + 1;
    final_report;
  end
  initial
  begin
    {rst_n, standby_mode, sleep_mode, debug_mode, psel, penable, pwrite} = 7'h00;
    paddr = 18'h0_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    err_count = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_start;
    t_freeze;
    t_overflow;
    final_report;
  end
endmodule
bind slow_clock_watchdog_timer slow_clock_watchdog_timer_assertions chk_inst
(
  .clk, .rst_n, .standby_mode, .sleep_mode, .debug_mode, .psel, .penable, .pready,
  .pslverr, .wdt_reset_pulse, .restart_address, .watchdog_active, .watchdog_count
);
